// [logic/mlf_stall_cfg.v]
// mlf_stall_cfg.v: stall fault response settings, AXI4-Lite slave, bridge state and fault pin
// assumes detector inputs are raw levels from another domain; one clock aclk, sync reset aresetn
//
// Functional notes
// - action codes 0h to 3h make a detected stall a latched fault and drive fault_out_n low.
// - codes 0h and 4h leave the bridge high impedance, codes 1h and 5h select recirculation.
// - codes 2h and 6h switch on every high-side transistor while the response is active.
// - codes 3h and 7h switch on every low-side transistor while the response is active.
// - codes 4h to 7h do not latch and resume by themselves after the retry interval.
// - code 8h only reports a stall and leaves the bridge alone.
// - codes 9h to Fh disable stall detection entirely.
// - the retry field picks 100, 500, 1000, 2000, 3000, 5000, 7500 or 10000 ms.
// - the second settings register sits at 94h and resets to zero.
// - bit 30 of the second register enables the overspeed check.
// - bit 29 of the second register enables the sync loss check.
// - bit 28 of the second register enables the open winding check.
//
// Local design decision: the AXI4-Lite register port.
`timescale 1ns/100ps
`include "mlf_defines.vh"
module mlf_stall_cfg #(
  parameter CYC_PER_MS = `MLF_CYC_PER_MS
) (
  input wire aclk,
  input wire aresetn,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire overspeed_detect,
  input wire sync_loss_detect,
  input wire open_winding_detect,
  output reg fault_out_n,
  output reg [1:0] bridge_state,
  output reg bridge_hold,
  output reg [2:0] high_side_on,
  output reg [2:0] low_side_on,
  output reg stall_report,
  output reg irq
);
  // ==================================================
  // registers
  // first settings keeps bits 6:0 only, upper bits read zero
  reg [31:0] fault_settings_first;
  reg [31:0] fault_settings_second;
  reg [2:0] irq_status;
  reg [2:0] irq_mask;
  wire [3:0] stall_action_select = fault_settings_first[`MLF_ACT_HI:`MLF_ACT_LO];
  wire [2:0] stall_recovery_delay = fault_settings_first[`MLF_DLY_HI:`MLF_DLY_LO];
  wire overspeed_check_on = fault_settings_second[`MLF_OVERSPEED_BIT];
  wire sync_loss_check_on = fault_settings_second[`MLF_SYNCLOSS_BIT];
  wire open_winding_check_on = fault_settings_second[`MLF_OPENWIND_BIT];
  // ==================================================
  // two-stage synchronisers for the detector levels
  // det_meta may be metastable, so only det_sync reads it
  reg [2:0] det_meta;
  reg [2:0] det_sync;
  always @(posedge aclk) begin
    if (!aresetn) begin
      det_meta <= 3'h0;
      det_sync <= 3'h0;
    end else begin
      det_meta <= {open_winding_detect, sync_loss_detect, overspeed_detect};
      det_sync <= det_meta;
    end
  end
  // ==================================================
  // stall qualification
  wire detect_on = (stall_action_select <= 4'h8);
  wire stall_raw = (det_sync[0] & overspeed_check_on) |
                   (det_sync[1] & sync_loss_check_on) |
                   (det_sync[2] & open_winding_check_on);
  wire stall = stall_raw & detect_on;
  // only a rising stall starts a response; a steady one must drop first
  reg stall_d;
  wire stall_rise = stall & ~stall_d;
  // ==================================================
  // response state machine
  localparam ST_IDLE = 2'h0;
  localparam ST_LATCH = 2'h1;
  localparam ST_RETRY = 2'h2;
  reg [1:0] state;
  reg [1:0] next_state;
  reg clear_req;
  wire retry_busy;
  wire retry_done;
  wire act_latch = (stall_action_select <= 4'h3);
  wire act_retry = stall_action_select[3:2] == 2'h1;
  wire start_retry = (state == ST_IDLE) & stall_rise & act_retry;
  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (stall_rise & act_latch) begin
          next_state = ST_LATCH;
        end else if (start_retry) begin
          next_state = ST_RETRY;
        end
      end
      ST_LATCH: begin
        if (clear_req) begin
          next_state = ST_IDLE;
        end
      end
      ST_RETRY: begin
        if (retry_done) begin
          next_state = ST_IDLE;
        end
      end
      default: next_state = ST_IDLE;
    endcase
  end
  // abort tied off: a started retry always runs its full interval
  mlf_retry_timer #(
    .CYC_PER_MS(CYC_PER_MS)
  ) u_timer (
    .aclk(aclk),
    .aresetn(aresetn),
    .start(start_retry),
    .abort(1'b0),
    .delay_sel(stall_recovery_delay),
    .busy(retry_busy),
    .done(retry_done)
  );
  // ==================================================
  // bridge mode remembered at entry so a rewrite cannot change a held response
  reg [1:0] held_mode;
  wire active = (state != ST_IDLE);
  // one switch request per half-bridge; one held code, so brakes never overlap
  genvar g;
  wire [2:0] next_high_side;
  wire [2:0] next_low_side;
  generate
    for (g = 0; g < 3; g = g + 1) begin : g_leg
      assign next_high_side[g] = active & (held_mode == `MLF_BR_HS_BRAKE);
      assign next_low_side[g] = active & (held_mode == `MLF_BR_LS_BRAKE);
    end
  endgenerate
  always @(posedge aclk) begin
    if (!aresetn) begin
      state <= ST_IDLE;
      stall_d <= 1'b0;
      held_mode <= `MLF_BR_HIZ;
      fault_out_n <= 1'b1;
      bridge_state <= `MLF_BR_HIZ;
      bridge_hold <= 1'b0;
      high_side_on <= 3'h0;
      low_side_on <= 3'h0;
      stall_report <= 1'b0;
    end else begin
      state <= next_state;
      stall_d <= stall;
      if (state == ST_IDLE && next_state != ST_IDLE) begin
        held_mode <= stall_action_select[1:0];
      end
      fault_out_n <= ~(state == ST_LATCH);
      bridge_hold <= active;
      bridge_state <= active ? held_mode : `MLF_BR_HIZ;
      high_side_on <= next_high_side;
      low_side_on <= next_low_side;
      stall_report <= stall;
    end
  end
  // ==================================================
  // axi4-lite write: address and data taken in either order
  reg [7:0] aw_addr;
  reg aw_have;
  reg [31:0] w_data;
  reg [3:0] w_strb;
  reg w_have;
  // a pending response holds off the next write until it is taken
  wire do_write = aw_have & w_have & ~s_axi_bvalid;
  reg [31:0] cur;
  reg hit;
  wire [31:0] merged;
  always @* begin
    cur = 32'h0;
    hit = 1'b1;
    case (aw_addr)
      `MLF_ADDR_CFG1: cur = fault_settings_first;
      `MLF_ADDR_CFG2: cur = fault_settings_second;
      `MLF_ADDR_STATUS: cur = 32'h0;
      `MLF_ADDR_MASK: cur = {29'h0, irq_mask};
      `MLF_ADDR_CTRL: cur = 32'h0;
      default: hit = 1'b0;
    endcase
  end
  // byte lanes without a strobe keep their old contents
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_lane
      assign merged[g*8 +: 8] = w_strb[g] ? w_data[g*8 +: 8] : cur[g*8 +: 8];
    end
  endgenerate
  // events: retry done, latched entry, any qualified stall rise
  wire [2:0] events = {retry_done, (state == ST_IDLE) & stall_rise & act_latch, stall_rise};
  wire [2:0] w1c = (do_write && aw_addr == `MLF_ADDR_STATUS) ? merged[2:0] : 3'h0;
  // set wins over a same-cycle write-one clear, bit by bit
  wire [2:0] next_status;
  generate
    for (g = 0; g < 3; g = g + 1) begin : g_status
      assign next_status[g] = events[g] | (irq_status[g] & ~w1c[g]);
    end
  endgenerate
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
      aw_have <= 1'b0;
      w_have <= 1'b0;
      aw_addr <= 8'h0;
      w_data <= 32'h0;
      w_strb <= 4'h0;
      fault_settings_first <= `MLF_RST_CFG1;
      fault_settings_second <= `MLF_RST_CFG2;
      irq_mask <= `MLF_RST_MASK;
      irq_status <= 3'h0;
      clear_req <= 1'b0;
      irq <= 1'b0;
    end else begin
      clear_req <= 1'b0;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr <= s_axi_awaddr;
        aw_have <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
        w_have <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (do_write) begin
        aw_have <= 1'b0;
        w_have <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= hit ? 2'h0 : 2'h2;
        case (aw_addr)
          `MLF_ADDR_CFG1: fault_settings_first <= {25'h0, merged[6:0]};
          `MLF_ADDR_CFG2: fault_settings_second <= merged;
          `MLF_ADDR_MASK: irq_mask <= merged[2:0];
          `MLF_ADDR_CTRL: clear_req <= merged[`MLF_CTRL_CLR];
          default: ;
        endcase
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
      irq_status <= next_status;
      irq <= |(next_status & irq_mask);
    end
  end
  // ==================================================
  // axi4-lite read, one cycle after address accept
  // ctrl readback: retry busy, state, fault
  wire [31:0] ctrl_view = {28'h0, retry_busy, state, ~fault_out_n};
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= 2'h0;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= 2'h0;
        case (s_axi_araddr)
          `MLF_ADDR_CFG1: s_axi_rdata <= fault_settings_first;
          `MLF_ADDR_CFG2: s_axi_rdata <= fault_settings_second;
          `MLF_ADDR_STATUS: s_axi_rdata <= {29'h0, irq_status};
          `MLF_ADDR_MASK: s_axi_rdata <= {29'h0, irq_mask};
          `MLF_ADDR_CTRL: s_axi_rdata <= ctrl_view;
          default: begin
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= 2'h2;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end
endmodule

// [logic/mlf_defines.vh]
// mlf_defines.vh: offsets, field positions, reset values and timing for the stall response block
// assumes inclusion by bare name from the design files under logic/
`ifndef MLF_DEFINES_VH
`define MLF_DEFINES_VH
// ==================================================
// register byte addresses
`define MLF_ADDR_CFG1 8'h90
`define MLF_ADDR_CFG2 8'h94
`define MLF_ADDR_STATUS 8'h98
`define MLF_ADDR_MASK 8'h9c
`define MLF_ADDR_CTRL 8'ha0
// ==================================================
// reset values
`define MLF_RST_CFG1 32'h00000000
`define MLF_RST_CFG2 32'h00000000
`define MLF_RST_MASK 3'h0
// ==================================================
// field positions
`define MLF_ACT_HI 6
`define MLF_ACT_LO 3
`define MLF_DLY_HI 2
`define MLF_DLY_LO 0
`define MLF_OVERSPEED_BIT 30
`define MLF_SYNCLOSS_BIT 29
`define MLF_OPENWIND_BIT 28
// status bits: 0 stall seen, 1 latched fault, 2 auto recovery done
`define MLF_ST_SEEN 0
`define MLF_ST_LATCH 1
`define MLF_ST_RECOV 2
// ctrl bit 0: write one clears a latched fault
`define MLF_CTRL_CLR 0
// ==================================================
// bridge output states
`define MLF_BR_HIZ 2'h0
`define MLF_BR_RECIRC 2'h1
`define MLF_BR_HS_BRAKE 2'h2
`define MLF_BR_LS_BRAKE 2'h3
// ==================================================
// timing: clock period in ns, retry times in ms
`define MLF_CLK_NS 10
`define MLF_RETRY_MS0 100
`define MLF_RETRY_MS1 500
`define MLF_RETRY_MS2 1000
`define MLF_RETRY_MS3 2000
`define MLF_RETRY_MS4 3000
`define MLF_RETRY_MS5 5000
`define MLF_RETRY_MS6 7500
`define MLF_RETRY_MS7 10000
`define MLF_CYC_PER_MS (1000000 / `MLF_CLK_NS)
`endif

// [logic/mlf_retry_timer.v]
// mlf_retry_timer.v: counts the selected recovery delay in clock cycles
// assumes aclk at the rate in mlf_defines.vh; start is a one-cycle pulse
`timescale 1ns/100ps
`include "mlf_defines.vh"
module mlf_retry_timer #(
  parameter CYC_PER_MS = `MLF_CYC_PER_MS
) (
  input wire aclk,
  input wire aresetn,
  input wire start,
  input wire abort,
  input wire [2:0] delay_sel,
  output reg busy,
  output reg done
);
  // ==================================================
  // delay lookup; counts fit 32 bits at the default rate
  reg [31:0] ms_sel;
  reg [31:0] limit;
  reg [31:0] count;
  always @* begin
    case (delay_sel)
      3'h0: ms_sel = `MLF_RETRY_MS0;
      3'h1: ms_sel = `MLF_RETRY_MS1;
      3'h2: ms_sel = `MLF_RETRY_MS2;
      3'h3: ms_sel = `MLF_RETRY_MS3;
      3'h4: ms_sel = `MLF_RETRY_MS4;
      3'h5: ms_sel = `MLF_RETRY_MS5;
      3'h6: ms_sel = `MLF_RETRY_MS6;
      default: ms_sel = `MLF_RETRY_MS7;
    endcase
    limit = ms_sel * CYC_PER_MS;
  end
  // ==================================================
  // delay latched at start so a later rewrite cannot stretch it
  reg [31:0] target;
  always @(posedge aclk) begin
    if (!aresetn) begin
      busy <= 1'b0;
      done <= 1'b0;
      count <= 32'h0;
      target <= 32'h0;
    end else begin
      done <= 1'b0;
      if (abort) begin
        busy <= 1'b0;
      end else if (start) begin
        busy <= 1'b1;
        count <= 32'h1;
        target <= limit;
      end else if (busy) begin
        if (count >= target) begin
          busy <= 1'b0;
          done <= 1'b1;
        end else begin
          count <= count + 32'h1;
        end
      end
    end
  end
endmodule

// [sim/mlf_stall_cfg_assertions.sv]
// checker: bridge, brake and fault pin relations of the stall block
// assumes bind onto mlf_stall_cfg, one clock aclk, sync reset aresetn
`timescale 1ns/100ps
module mlf_stall_chk (
  input wire aclk,
  input wire aresetn,
  input wire fault_out_n,
  input wire [1:0] bridge_state,
  input wire bridge_hold,
  input wire [2:0] high_side_on,
  input wire [2:0] low_side_on,
  input wire irq
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ====================
  // bridge output states
  property p_hs;
    bridge_hold && bridge_state == 2'h2 |-> high_side_on == 3'h7 && low_side_on == 3'h0;
  endproperty
  a_hs: assert property (p_hs) else $error("high-side brake wrong");
  property p_ls;
    bridge_hold && bridge_state == 2'h3 |-> low_side_on == 3'h7 && high_side_on == 3'h0;
  endproperty
  a_ls: assert property (p_ls) else $error("low-side brake wrong");
  property p_hiz;
    bridge_hold && bridge_state < 2'h2 |-> high_side_on == 3'h0 && low_side_on == 3'h0;
  endproperty
  a_hiz: assert property (p_hiz) else $error("brake on in hi-z or recirc");
  // idle bridge: no response means no action at all
  property p_idle;
    !bridge_hold |-> bridge_state == 2'h0 && high_side_on == 3'h0 && low_side_on == 3'h0;
  endproperty
  a_idle: assert property (p_idle) else $error("bridge acts without response");
  // mode is captured at entry, so it must not drift
  property p_mode;
    bridge_hold && $past(bridge_hold) |-> $stable(bridge_state);
  endproperty
  a_mode: assert property (p_mode) else $error("bridge mode changed in response");
  // ====================
  // fault pin
  property p_fall;
    $fell(fault_out_n) |-> $rose(bridge_hold);
  endproperty
  a_fall: assert property (p_fall) else $error("fault without bridge response");
  property p_keep;
    $fell(fault_out_n) |-> !fault_out_n [*3];
  endproperty
  a_keep: assert property (p_keep) else $error("latched fault dropped early");
  property p_fhold;
    !fault_out_n |-> bridge_hold;
  endproperty
  a_fhold: assert property (p_fhold) else $error("latched fault lost bridge state");
  // ====================
  // coverage
  c_hs: cover property (bridge_hold && bridge_state == 2'h2);
  c_latch: cover property (!fault_out_n);
  c_irq: cover property (irq);
endmodule
bind mlf_stall_cfg mlf_stall_chk u_chk (.*);

// [sim/mlf_stall_cfg_tb.sv]
// testbench: register access, stall response codes, retry timing, irq
// assumes mlf_stall_cfg built with CYC_PER_MS 2, so 1 ms is 2 cycles
`timescale 1ns/100ps
module mlf_stall_cfg_tb;
  logic aclk = 1'b0, aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd_d;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
  logic s_axi_bready = 1'b1, s_axi_rready = 1'b1;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic fault_out_n, bridge_hold, stall_report, irq;
  logic [1:0] s_axi_bresp, s_axi_rresp, bridge_state, rd_r, wr_r;
  logic [2:0] high_side_on, low_side_on, det = 3'h0;
  int err_count = 0, cmp_count = 0, n;
  int ms [8] = '{100, 500, 1000, 2000, 3000, 5000, 7500, 10000};
  always #5 aclk = ~aclk;
  // short ms keeps the 10 s retry inside a sane run
  mlf_stall_cfg #(.CYC_PER_MS(2)) dut (.*, .overspeed_detect(det[2]), .sync_loss_detect(det[1]),
    .open_winding_detect(det[0]));
  // ====================
  // helpers
  task results;
    $display("errors %0d checks %0d", err_count, cmp_count);
    if (err_count == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task hang;
    err_count++;
    results;
  endtask
  task chk(input logic [31:0] s, e, input string nm);
    cmp_count++;
    if (s !== e) begin
      err_count++;
      $display("[FAIL] %s exp %0h got %0h", nm, e, s);
    end
  endtask
  // bready held high, so the response is taken on sight
  task wr(input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid} <= 2'b11;
    for (i = 0; i < 50; i++) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    if (i == 50) hang;
    wr_r = s_axi_bresp;
  endtask
  task rd(input logic [7:0] a);
    int i;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    if (i == 50) hang;
    rd_d = s_axi_rdata;
    rd_r = s_axi_rresp;
  endtask
  task hw(input logic v);
    n = 0;
    while (bridge_hold !== v && n < 25000) begin
      @(posedge aclk);
      n++;
    end
    if (n == 25000) hang;
  endtask
  // ====================
  // scenarios
  task t_regs;
    rd(8'h94);
    chk(rd_d, 32'h0, "cfg2 reset");
    wr(8'h94, 32'hffffffff);
    chk(wr_r, 2'h0, "cfg2 write resp");
    rd(8'h94);
    chk(rd_d, 32'hffffffff, "cfg2 rw");
    rd(8'h90);
    chk(rd_d, 32'h0, "cfg1 reset");
    rd(8'hfc);
    chk(rd_r, 2'h2, "unmapped resp");
    wr(8'hfc, 32'h1);
    chk(wr_r, 2'h2, "unmapped write resp");
    wr(8'h94, 32'h40000000);
  endtask
  task t_latch;
    for (int c = 0; c < 4; c++) begin
      wr(8'h90, c << 3);
      det <= 3'h4;
      hw(1'b1);
      chk(fault_out_n, 1'b0, "fault pin");
      chk(bridge_state, c, "mode");
      chk(high_side_on, (c == 2) ? 3'h7 : 3'h0, "high side");
      chk(low_side_on, (c == 3) ? 3'h7 : 3'h0, "low side");
      det <= 3'h0;
      repeat (20) @(posedge aclk);
      chk(fault_out_n, 1'b0, "held");
      wr(8'ha0, 32'h1);
      repeat (2) @(posedge aclk);
      chk(bridge_hold, 1'b0, "cleared");
    end
  endtask
  task t_auto;
    for (int d = 0; d < 8; d++) begin
      wr(8'h90, ((4 + d % 4) << 3) | d);
      det <= 3'h4;
      hw(1'b1);
      chk(fault_out_n, 1'b1, "no latch");
      chk(bridge_state, d % 4, "mode");
      chk(high_side_on, (d % 4 == 2) ? 3'h7 : 3'h0, "auto high side");
      chk(low_side_on, (d % 4 == 3) ? 3'h7 : 3'h0, "auto low side");
      det <= 3'h0;
      hw(1'b0);
      chk(n / 2, ms[d], "retry ms");
    end
  endtask
  task t_report;
    rd(8'h98);
    chk(rd_d, 32'h7, "status sticky");
    wr(8'h98, 32'h7);
    rd(8'h98);
    chk(rd_d, 32'h0, "status cleared");
    wr(8'h9c, 32'h1);
    wr(8'h90, 32'h40);
    for (int k = 0; k < 3; k++) begin
      wr(8'h94, 32'h10000000 << k);
      det <= 3'h1 << k;
      repeat (8) @(posedge aclk);
      chk(stall_report, 1'b1, "report");
      chk(bridge_hold, 1'b0, "no action");
      chk(irq, 1'b1, "irq");
      det <= 3'h0;
      wr(8'h98, 32'h1);
      wr(8'h94, 32'h0);
      det <= 3'h1 << k;
      repeat (8) @(posedge aclk);
      chk(stall_report, 1'b0, "check off");
      chk(irq, 1'b0, "irq cleared");
      det <= 3'h0;
    end
    wr(8'h94, 32'h40000000);
    for (int k = 9; k < 16; k++) begin
      wr(8'h90, k << 3);
      det <= 3'h4;
      repeat (8) @(posedge aclk);
      chk(stall_report | bridge_hold, 1'b0, "disabled");
      det <= 3'h0;
    end
  endtask
  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs;
    t_latch;
    t_auto;
    t_report;
    results;
  end
endmodule
